// file: inc/smwl_pkg.sv
// package for the second main window layer configuration block
// assumes a 32-bit axi4-lite slave port and a 16 bpp display buffer
package smwl_pkg;

	// ********************************************************
	// register indices, byte address is four times the index
	// ********************************************************
	localparam logic [9:0] SMWL_IDX_START_LO = 10'h24A;
	localparam logic [9:0] SMWL_IDX_START_HI = 10'h24C;
	localparam logic [9:0] SMWL_IDX_LINE_OFS = 10'h24E;
	localparam logic [9:0] SMWL_IDX_WIDTH = 10'h250;
	localparam logic [9:0] SMWL_IDX_HEIGHT = 10'h252;
	localparam logic [9:0] SMWL_IDX_STATUS = 10'h254;

	// ********************************************************
	// field layout and writable masks
	// ********************************************************
	localparam logic [15:0] SMWL_MASK_START_LO = 16'hFFFE;
	localparam logic [15:0] SMWL_MASK_START_HI = 16'h000F;
	localparam logic [15:0] SMWL_MASK_LINE_OFS = 16'h3FFE;
	localparam logic [15:0] SMWL_MASK_SIZE = 16'h03FF;
	localparam int SMWL_BIT_VDBL = 13;
	localparam int SMWL_BIT_HDBL = 12;
	localparam int SMWL_BIT_STAT_ACTIVE = 15;
	localparam int SMWL_BIT_STAT_VREP = 14;
	localparam int SMWL_BIT_STAT_HREP = 13;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [15:0] SMWL_RST_START_LO = 16'h0000;
	localparam logic [15:0] SMWL_RST_START_HI = 16'h0000;
	localparam logic [15:0] SMWL_RST_LINE_OFS = 16'h0000;
	localparam logic [15:0] SMWL_RST_WIDTH = 16'h0000;
	localparam logic [15:0] SMWL_RST_HEIGHT = 16'h0000;

	// ********************************************************
	// buffer geometry and bus answers
	// ********************************************************
	localparam logic [19:0] SMWL_PIXEL_BYTES = 20'h00002;
	localparam logic [1:0] SMWL_RESP_OKAY = 2'h0;
	localparam logic [1:0] SMWL_RESP_SLVERR = 2'h2;

	// scanner states, gray along idle -> run -> done
	typedef enum logic [1:0] {
		SMWL_ST_IDLE = 2'h0,
		SMWL_ST_RUN = 2'h1,
		SMWL_ST_DONE = 2'h3
	} smwl_state_type;

endpackage

// file: hdl/smwl_scan.sv
// scan address generator of the second main window layer
// assumes frame_start and pix_adv come from logic on clk
`timescale 1ns/1ps
module smwl_scan import smwl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_start,
	input wire logic pix_adv,
	input wire logic [19:0] start_addr,
	input wire logic [11:0] stride,
	input wire logic hdbl,
	input wire logic vdbl,
	input wire logic [9:0] width_m1,
	input wire logic [9:0] height_m1,
	output logic [19:0] fetch_addr_r,
	output logic active_r,
	output logic frame_done_r,
	output logic [9:0] src_line_r,
	output logic hrep_r,
	output logic vrep_r
);

	// ********************************************************
	// state
	// ********************************************************
	smwl_state_type state_r, state_nxt;
	logic [19:0] fetch_addr_nxt, line_base_r, line_base_nxt;
	logic [9:0] src_x_r, src_x_nxt, src_line_nxt;
	logic hrep_nxt, vrep_nxt, done_nxt;
	logic [11:0] stride_r, stride_nxt;
	logic hdbl_r, hdbl_nxt, vdbl_r, vdbl_nxt;
	logic [9:0] w_r, w_nxt, h_r, h_nxt;

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		state_nxt = state_r;
		fetch_addr_nxt = fetch_addr_r;
		line_base_nxt = line_base_r;
		src_x_nxt = src_x_r;
		src_line_nxt = src_line_r;
		hrep_nxt = hrep_r;
		vrep_nxt = vrep_r;
		done_nxt = 1'b0;
		stride_nxt = stride_r;
		hdbl_nxt = hdbl_r;
		vdbl_nxt = vdbl_r;
		w_nxt = w_r;
		h_nxt = h_r;
		if (frame_start) begin
			// settings captured once per frame
			state_nxt = SMWL_ST_RUN;
			fetch_addr_nxt = start_addr;
			line_base_nxt = start_addr;
			src_x_nxt = 10'h000;
			src_line_nxt = 10'h000;
			hrep_nxt = 1'b0;
			vrep_nxt = 1'b0;
			stride_nxt = stride;
			hdbl_nxt = hdbl;
			vdbl_nxt = vdbl;
			w_nxt = width_m1;
			h_nxt = height_m1;
		end else begin
			case (state_r)
				SMWL_ST_RUN: begin
					if (pix_adv) begin
						if (hdbl_r && !hrep_r) begin
							hrep_nxt = 1'b1;
						end else begin
							hrep_nxt = 1'b0;
							if (src_x_r != w_r) begin
								src_x_nxt = 10'(src_x_r + 10'h001);
								fetch_addr_nxt = 20'(fetch_addr_r + SMWL_PIXEL_BYTES);
							end else begin
								src_x_nxt = 10'h000;
								if (vdbl_r && !vrep_r) begin
									vrep_nxt = 1'b1;
									fetch_addr_nxt = line_base_r;
								end else begin
									vrep_nxt = 1'b0;
									if (src_line_r != h_r) begin
										src_line_nxt = 10'(src_line_r + 10'h001);
										line_base_nxt = 20'(line_base_r + {8'h00, stride_r});
										fetch_addr_nxt = 20'(line_base_r + {8'h00, stride_r});
									end else begin
										state_nxt = SMWL_ST_DONE;
										done_nxt = 1'b1;
									end
								end
							end
						end
					end
				end
				SMWL_ST_DONE: begin
					state_nxt = SMWL_ST_IDLE;
				end
				SMWL_ST_IDLE: begin
					state_nxt = SMWL_ST_IDLE;
				end
				default: begin
					state_nxt = SMWL_ST_IDLE;
				end
			endcase
		end
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= SMWL_ST_IDLE;
			fetch_addr_r <= 20'h00000;
			line_base_r <= 20'h00000;
			src_x_r <= 10'h000;
			src_line_r <= 10'h000;
			hrep_r <= 1'b0;
			vrep_r <= 1'b0;
			frame_done_r <= 1'b0;
			active_r <= 1'b0;
			stride_r <= 12'h000;
			hdbl_r <= 1'b0;
			vdbl_r <= 1'b0;
			w_r <= 10'h000;
			h_r <= 10'h000;
		end else begin
			state_r <= state_nxt;
			fetch_addr_r <= fetch_addr_nxt;
			line_base_r <= line_base_nxt;
			src_x_r <= src_x_nxt;
			src_line_r <= src_line_nxt;
			hrep_r <= hrep_nxt;
			vrep_r <= vrep_nxt;
			frame_done_r <= done_nxt;
			active_r <= (state_nxt == SMWL_ST_RUN);
			stride_r <= stride_nxt;
			hdbl_r <= hdbl_nxt;
			vdbl_r <= vdbl_nxt;
			w_r <= w_nxt;
			h_r <= h_nxt;
		end
	end

endmodule

// file: hdl/smwl_top.sv
// register bank and scan control of the second main window layer
// assumes an axi4-lite master on clk and a display timing source on clk
// Summary of operation
// - The 20-bit buffer start address is bits 15-1 of the low register and bits 3-0 of the high one, bit 0 zero.
// - Line offset bit 13 set turns on vertical doubling of the window; clear it does nothing.
// - Line offset bit 12 set turns on horizontal doubling of the window; clear it does nothing.
// - Each source line starts at the previous source line start plus the stride in bits 11-1, bit 0 zero; a vertical repeat reuses its start.
// - Width field bits 9-0 hold the image width in pixels minus one.
// - Height field bits 9-0 hold the image height in pixels minus one.
`timescale 1ns/1ps
module smwl_top import smwl_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frame_start,
	input wire logic pix_adv,
	output logic [19:0] fetch_addr,
	output logic layer_active,
	output logic frame_done,
	output logic pix_repeat
);

	// ********************************************************
	// register file state
	// ********************************************************
	logic [15:0] start_lo_r, start_lo_nxt;
	logic [15:0] start_hi_r, start_hi_nxt;
	logic [15:0] line_ofs_r, line_ofs_nxt;
	logic [15:0] width_r, width_nxt;
	logic [15:0] height_r, height_nxt;

	// ********************************************************
	// bus channel state
	// ********************************************************
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [9:0] aw_idx_r, aw_idx_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [1:0] wstrb_r, wstrb_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	// ********************************************************
	// scanner wires
	// ********************************************************
	logic [19:0] scan_addr;
	logic scan_active;
	logic scan_done;
	logic [9:0] scan_line;
	logic scan_hrep;
	logic scan_vrep;
	logic [15:0] status_val;
	logic [19:0] start_addr;
	logic [15:0] wr_lanes;

	assign start_addr = {start_hi_r[3:0], start_lo_r[15:1], 1'b0};
	assign status_val = {scan_active, scan_vrep, scan_hrep, 3'h0, scan_line};
	assign wr_lanes = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	// ********************************************************
	// write channels and register update
	// ********************************************************
	function automatic logic [15:0] smwl_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] lanes, input logic [15:0] mask);
		smwl_merge = ((old & ~lanes) | (nw & lanes)) & mask;
	endfunction

	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		aw_idx_nxt = aw_idx_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		start_lo_nxt = start_lo_r;
		start_hi_nxt = start_hi_r;
		line_ofs_nxt = line_ofs_r;
		width_nxt = width_r;
		height_nxt = height_r;
		if (s_axi_awvalid && awready_r) begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && wready_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[15:0];
			wstrb_nxt = s_axi_wstrb[1:0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_held_r && w_held_r && !bvalid_r) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = SMWL_RESP_OKAY;
			case (aw_idx_r)
				SMWL_IDX_START_LO: begin
					start_lo_nxt = smwl_merge(start_lo_r, wdata_r, wr_lanes, SMWL_MASK_START_LO);
				end
				SMWL_IDX_START_HI: begin
					start_hi_nxt = smwl_merge(start_hi_r, wdata_r, wr_lanes, SMWL_MASK_START_HI);
				end
				SMWL_IDX_LINE_OFS: begin
					line_ofs_nxt = smwl_merge(line_ofs_r, wdata_r, wr_lanes, SMWL_MASK_LINE_OFS);
				end
				SMWL_IDX_WIDTH: begin
					width_nxt = smwl_merge(width_r, wdata_r, wr_lanes, SMWL_MASK_SIZE);
				end
				SMWL_IDX_HEIGHT: begin
					height_nxt = smwl_merge(height_r, wdata_r, wr_lanes, SMWL_MASK_SIZE);
				end
				SMWL_IDX_STATUS: begin
					bresp_nxt = SMWL_RESP_OKAY;
				end
				default: begin
					bresp_nxt = SMWL_RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = !aw_held_nxt;
		wready_nxt = !w_held_nxt;
	end

	// ********************************************************
	// read channel
	// ********************************************************
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = SMWL_RESP_OKAY;
			case (s_axi_araddr[11:2])
				SMWL_IDX_START_LO: begin
					rdata_nxt = {16'h0000, start_lo_r};
				end
				SMWL_IDX_START_HI: begin
					rdata_nxt = {16'h0000, start_hi_r};
				end
				SMWL_IDX_LINE_OFS: begin
					rdata_nxt = {16'h0000, line_ofs_r};
				end
				SMWL_IDX_WIDTH: begin
					rdata_nxt = {16'h0000, width_r};
				end
				SMWL_IDX_HEIGHT: begin
					rdata_nxt = {16'h0000, height_r};
				end
				SMWL_IDX_STATUS: begin
					rdata_nxt = {16'h0000, status_val};
				end
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = SMWL_RESP_SLVERR;
				end
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_lo_r <= SMWL_RST_START_LO;
			start_hi_r <= SMWL_RST_START_HI;
			line_ofs_r <= SMWL_RST_LINE_OFS;
			width_r <= SMWL_RST_WIDTH;
			height_r <= SMWL_RST_HEIGHT;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 10'h000;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
		end else begin
			start_lo_r <= start_lo_nxt;
			start_hi_r <= start_hi_nxt;
			line_ofs_r <= line_ofs_nxt;
			width_r <= width_nxt;
			height_r <= height_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			aw_idx_r <= aw_idx_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ********************************************************
	// layer scanner
	// ********************************************************
	smwl_scan u_scan (
		.clk(clk),
		.rst_n(rst_n),
		.frame_start(frame_start),
		.pix_adv(pix_adv),
		.start_addr(start_addr),
		.stride({line_ofs_r[11:1], 1'b0}),
		.hdbl(line_ofs_r[SMWL_BIT_HDBL]),
		.vdbl(line_ofs_r[SMWL_BIT_VDBL]),
		.width_m1(width_r[9:0]),
		.height_m1(height_r[9:0]),
		.fetch_addr_r(scan_addr),
		.active_r(scan_active),
		.frame_done_r(scan_done),
		.src_line_r(scan_line),
		.hrep_r(scan_hrep),
		.vrep_r(scan_vrep)
	);

	assign fetch_addr = scan_addr;
	assign layer_active = scan_active;
	assign frame_done = scan_done;
	assign pix_repeat = scan_hrep | scan_vrep;

endmodule

// file: bench/smwl_top_asserts.sv
// concurrent checks on the ports of the layer block
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
module smwl_top_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic frame_start,
	input wire logic pix_adv,
	input wire logic [19:0] fetch_addr,
	input wire logic layer_active,
	input wire logic frame_done
);
	// ********
	// bus and scan checks
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_write_stall: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address not stalled");
	a_frame_load: assert property (frame_start |=> layer_active)
		else $error("scan not started");
	a_addr_hold: assert property (layer_active && !pix_adv && !frame_start |=> $stable(fetch_addr))
		else $error("address moved without advance");
	a_done_pulse: assert property (frame_done |-> !layer_active ##1 !frame_done)
		else $error("frame done not a single pulse");
	a_done_cause: assert property ($rose(frame_done) |-> $past(pix_adv) && $past(layer_active))
		else $error("frame done without advance");
endmodule

// file: bench/smwl_top_tb_top.sv
// self-checking bench of the second main window layer block
// assumes a 100 MHz clock and the register map of smwl_pkg
`timescale 1ns/1ps
module smwl_top_tb_top import smwl_pkg::*; ;
	// ********
	// signals
	// ********
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic frame_start = 1'b0, pix_adv = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic layer_active, frame_done, pix_repeat;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [19:0] fetch_addr;
	logic [3:0] wstrb_v = 4'h3;
	int miscompares = 0, n_checks = 0, cycles = 0;
	localparam logic [9:0] IDX_TAB [5] = '{SMWL_IDX_START_LO, SMWL_IDX_START_HI, SMWL_IDX_LINE_OFS, SMWL_IDX_WIDTH,
		SMWL_IDX_HEIGHT};
	localparam logic [15:0] MASK_TAB [5] = '{SMWL_MASK_START_LO, SMWL_MASK_START_HI, SMWL_MASK_LINE_OFS, SMWL_MASK_SIZE,
		SMWL_MASK_SIZE};

	smwl_top smwl_top_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_start(frame_start), .pix_adv(pix_adv),
		.fetch_addr(fetch_addr), .layer_active(layer_active), .frame_done(frame_done), .pix_repeat(pix_repeat));

	always #5 clk = ~clk;

	// ********
	// tasks
	// ********
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] data, output logic [1:0] resp);
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= data;
		s_axi_wstrb <= wstrb_v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge clk);
			if (aw_p && s_axi_awready === 1'b1) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready === 1'b1) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdr(input logic [9:0] idx, output logic [31:0] data, output logic [1:0] resp);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// one frame with pix_adv held high, every displayed pixel compared
	task automatic scan(input logic hd, input logic vd, input logic [19:0] base, input logic [19:0] step,
		input int w, input int h);
		int l, r, p, q;
		logic [19:0] ea;
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		pix_adv <= 1'b1;
		for (l = 0; l <= h; l++)
			for (r = 0; r <= int'(vd); r++)
				for (p = 0; p <= w; p++)
					for (q = 0; q <= int'(hd); q++) begin
						@(posedge clk);
						ea = base + 20'(l) * step + 20'(p) * SMWL_PIXEL_BYTES;
						chk("fetch_addr", {12'h0, ea}, {12'h0, fetch_addr});
						chk("pix_repeat", {31'h0, 1'(r | q)}, {31'h0, pix_repeat});
					end
		pix_adv <= 1'b0;
		@(posedge clk);
		chk("frame_done", 32'h1, {31'h0, frame_done});
		chk("layer_active", 32'h0, {31'h0, layer_active});
	endtask

	// ********
	// tests
	// ********
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			rdr(IDX_TAB[i], rd, rsp);
			chk("reset value", 32'h0, rd);
		end
		$display("test reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(IDX_TAB[i], 32'hFFFF_FFFF, rsp);
			chk("bresp", {30'h0, SMWL_RESP_OKAY}, {30'h0, rsp});
			rdr(IDX_TAB[i], rd, rsp);
			chk("field mask", {16'h0, MASK_TAB[i]}, rd);
			wr(IDX_TAB[i], 32'h0, rsp);
			rdr(IDX_TAB[i], rd, rsp);
			chk("cleared", 32'h0, rd);
		end
		$display("test field masks done");
		wstrb_v = 4'h1;
		wr(SMWL_IDX_WIDTH, 32'h0000_FFFF, rsp);
		rdr(SMWL_IDX_WIDTH, rd, rsp);
		chk("lane 0 write", 32'h0000_00FF, rd);
		wstrb_v = 4'h2;
		wr(SMWL_IDX_WIDTH, 32'h0000_FF00, rsp);
		rdr(SMWL_IDX_WIDTH, rd, rsp);
		chk("lane 1 write", 32'h0000_03FF, rd);
		wstrb_v = 4'h3;
		$display("test byte strobes done");
		rdr(10'h256, rd, rsp);
		chk("unmapped rresp", {30'h0, SMWL_RESP_SLVERR}, {30'h0, rsp});
		chk("unmapped rdata", 32'h0, rd);
		wr(10'h256, 32'h1234, rsp);
		chk("unmapped bresp", {30'h0, SMWL_RESP_SLVERR}, {30'h0, rsp});
		wr(SMWL_IDX_STATUS, 32'hFFFF, rsp);
		chk("status bresp", {30'h0, SMWL_RESP_OKAY}, {30'h0, rsp});
		rdr(SMWL_IDX_STATUS, rd, rsp);
		chk("status idle", 32'h0, rd);
		$display("test unmapped and status done");
		wr(SMWL_IDX_START_LO, 32'h0000_2347, rsp);
		wr(SMWL_IDX_START_HI, 32'h0000_0001, rsp);
		wr(SMWL_IDX_WIDTH, 32'h0000_0002, rsp);
		wr(SMWL_IDX_HEIGHT, 32'h0000_0001, rsp);
		for (int m = 0; m < 4; m++) begin
			wr(SMWL_IDX_LINE_OFS, {18'h0, m[1], m[0], 12'h041}, rsp);
			scan(m[0], m[1], 20'h12346, 20'h00040, 2, 1);
		end
		rdr(SMWL_IDX_STATUS, rd, rsp);
		chk("status after frame", 32'h0000_0001, rd);
		$display("test scans done");
		final_report();
	end
endmodule

bind smwl_top smwl_top_asserts smwl_top_asserts_i (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .frame_start(frame_start), .pix_adv(pix_adv), .fetch_addr(fetch_addr),
	.layer_active(layer_active), .frame_done(frame_done));
